//--- rtl/spc_map.svh
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

// Serial clock half periods in bus clocks, chosen by the two baud bits.
`define SPC_HALF_0 5'd4
`define SPC_HALF_1 5'd8
`define SPC_HALF_2 5'd12
`define SPC_HALF_3 5'd16

// Sixteen serial clock edges make one byte.
`define SPC_LAST_EDGE 4'd15
`define SPC_LAST_BIT 3'd7

`define SPC_BYTE_RST 8'h00
`define SPC_TXE_RST 1'b1

`endif

//--- rtl/spc_pkg.sv
package spc_pkg;

    typedef enum logic [1:0] {
        S_IDLE = 2'b01,
        S_RUN = 2'b10
    } spc_state_t;

    typedef struct packed {
        logic unit_enable_bit;
        logic master_select;
        logic clock_phase;
        logic clock_polarity;
        logic wired_or_select;
        logic select_fault_enable;
        logic error_irq_enable;
        logic rx_irq_enable;
        logic tx_irq_enable;
        logic baud_select_hi;
        logic baud_select_lo;
    } spc_cfg_t;

    typedef struct packed {
        logic data_wr;
        logic [7:0] wdata;
        logic data_rd;
        logic status_rd;
        logic ctrl_wr;
    } spc_acc_t;

    typedef struct packed {
        logic wait_mode;
        logic stop_mode;
        logic break_state;
        logic break_clear_enable;
    } spc_pwr_t;

    typedef struct packed {
        logic enabled;
        logic tx_buffer_empty_flag;
        logic rx_full_flag;
        logic overrun_flag;
        logic select_fault_flag;
    } spc_stat_t;

    typedef struct packed {
        logic ss_m;
        logic ss_s;
        logic ss_p;
        logic mi_m;
        logic mi_s;
        logic tg_m;
        logic tg_s;
        logic tg_p;
        logic slv;
        logic en_off;
        spc_stat_t stat;
        logic arm_rx;
        logic arm_select_fault_flag;
        logic slv_act;
        logic [7:0] txbuf;
        logic [7:0] rxbuf;
        logic [7:0] sh;
        logic rbit;
        spc_state_t st;
        logic [4:0] hcnt;
        logic [3:0] ecnt;
        logic sck;
        logic sck_oe;
        logic mosi_o;
        logic mosi_oe;
        logic miso_oe;
        logic pins;
        logic ss_own;
        logic wake;
    } spc_st_t;

endpackage : spc_pkg

//--- rtl/spc_core.sv
// Overview of operation
// - With no new byte queued, the slave sends back the byte it just received.
// - Idle unit moves the queued byte and sets empty flag next cycle.
// - A selected slave loads its shift register only after the byte ends.
// - System reset returns every bit, flag and state to reset values.
// - Enable low sets empty, aborts, clears shifter and counter, frees pins.
// - Disabling keeps control bits and receive, overrun, fault flags.
// - Master select fault with detection on disables the unit.
// - In wait the unit runs, ignores CPU access, requests wake-up.
// - In stop all bus-clocked state holds; reset on exit aborts the transfer.
// - In break without clear enable, access leaves flags untouched.
// - In break with clear enable, the two-step access clears flags as usual; a new byte sets them again.
// - Data write in locked break neither queues nor starts a byte.
// - Wired-OR select makes the data-out line open-drain.
// - Slave data-out is driven only when slave and selected.
// - Enabled unit owns data and clock pin directions.
// - Master drives serial clock; one byte takes eight clock cycles.
// - Deselected slave ignores serial clock edges.
// - Slave always takes select as input; enable bit only masks faults.
// - Disabled or master without detection leaves select to the port.
// - Empty flag sets on buffer-to-shifter move, full flag on receive.
`timescale 1ns/1ps
`include "spc_map.svh"

module spc_core (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic SCK_IN,
    input wire logic SS_N,
    input wire logic MOSI_I,
    input wire logic MISO_I,
    input wire spc_pkg::spc_cfg_t CFG,
    input wire spc_pkg::spc_acc_t ACC,
    input wire spc_pkg::spc_pwr_t PWR,
    output logic SCK_O,
    output logic SCK_OE,
    output logic MOSI_O,
    output logic MOSI_OE,
    output logic MISO_O,
    output logic MISO_OE,
    output logic PINS_OWNED,
    output logic SS_OWNED,
    output logic WAKE,
    output spc_pkg::spc_stat_t STATUS,
    output logic [7:0] RDATA
);
    import spc_pkg::*;

    spc_st_t q;
    spc_st_t d;
    logic en_eff;
    logic m_on;
    logic sl_on;
    logic acc_ok;
    logic done;
    logic samp;
    logic rx_evt;
    logic [7:0] byte_in;
    logic [4:0] half;
    logic miso_bit;
    logic lk_rst;
    logic lk_off;
    logic [2:0] lk_cnt;
    logic [7:0] lk_sh;
    logic [7:0] lk_buf;
    logic lk_tog;

    assign en_eff = CFG.unit_enable_bit & ~q.en_off;
    assign m_on = en_eff & CFG.master_select;
    assign sl_on = en_eff & ~CFG.master_select;
    // CPU access is dropped in wait and while break protects the flags.
    assign acc_ok = ~PWR.wait_mode &
        ~(PWR.break_state & ~PWR.break_clear_enable);
    assign done = sl_on & (q.tg_s ^ q.tg_p);
    assign samp = CFG.clock_phase ? q.ecnt[0] : ~q.ecnt[0];

    // Slave shifter on the outside clock; deselect holds it in reset.
    assign lk_rst = SS_N | ~q.slv;
    assign lk_off = ~q.slv;

    always_ff @(posedge SCK_IN or posedge lk_rst) begin
        if (lk_rst) begin
            lk_cnt <= 3'd0;
            lk_sh <= `SPC_BYTE_RST;
        end else begin
            lk_sh <= {lk_sh[6:0], MOSI_I};
            lk_cnt <= lk_cnt + 3'd1;
        end
    end

    // The toggle tells the bus side that lk_buf holds a whole byte.
    always_ff @(posedge SCK_IN or posedge lk_off) begin
        if (lk_off) begin
            lk_tog <= 1'b0;
            lk_buf <= `SPC_BYTE_RST;
        end else if (lk_cnt == `SPC_LAST_BIT) begin
            lk_tog <= ~lk_tog;
            lk_buf <= {lk_sh[6:0], MOSI_I};
        end
    end

    // The slave shifter is frozen while a byte is shifting, so it may feed the pin.
    assign miso_bit = q.sh[`SPC_LAST_BIT - lk_cnt];
    assign MISO_O = miso_bit & ~CFG.wired_or_select;
    assign MISO_OE = q.miso_oe & ~(CFG.wired_or_select & miso_bit);

    always_comb begin
        case ({CFG.baud_select_hi, CFG.baud_select_lo})
            2'b00: half = `SPC_HALF_0;
            2'b01: half = `SPC_HALF_1;
            2'b10: half = `SPC_HALF_2;
            default: half = `SPC_HALF_3;
        endcase
    end

    always_comb begin
        d = q;
        rx_evt = 1'b0;
        byte_in = `SPC_BYTE_RST;
        if (!PWR.stop_mode) begin
            d.ss_m = SS_N;
            d.ss_s = q.ss_m;
            d.ss_p = q.ss_s;
            d.mi_m = MISO_I;
            d.mi_s = q.mi_m;
            d.tg_m = lk_tog;
            d.tg_s = q.tg_m;
            d.tg_p = q.tg_s;
            if (acc_ok) begin
                if (ACC.status_rd) begin
                    d.arm_rx = q.stat.rx_full_flag | q.stat.overrun_flag;
                    d.arm_select_fault_flag = q.stat.select_fault_flag;
                end
                if (ACC.data_rd) begin
                    d.stat.rx_full_flag = 1'b0;
                    if (q.arm_rx) begin
                        d.stat.overrun_flag = 1'b0;
                    end
                    d.arm_rx = 1'b0;
                end
                if (ACC.ctrl_wr && q.arm_select_fault_flag &&
                    !(m_on && CFG.select_fault_enable && !q.ss_s)) begin
                    d.stat.select_fault_flag = 1'b0;
                    d.arm_select_fault_flag = 1'b0;
                end
                if (ACC.data_wr) begin
                    d.txbuf = ACC.wdata;
                    d.stat.tx_buffer_empty_flag = 1'b0;
                end
            end
            if (!CFG.unit_enable_bit) begin
                d.en_off = 1'b0;
            end
            if (m_on) begin
                if (CFG.select_fault_enable && !q.ss_s) begin
                    d.stat.select_fault_flag = 1'b1;
                    d.en_off = 1'b1;
                end
                case (q.st)
                    S_IDLE: begin
                        d.sck = CFG.clock_polarity;
                        if (!q.stat.tx_buffer_empty_flag) begin
                            d.sh = q.txbuf;
                            d.stat.tx_buffer_empty_flag = 1'b1;
                            d.hcnt = 5'd0;
                            d.ecnt = 4'd0;
                            d.st = S_RUN;
                        end
                    end
                    S_RUN: begin
                        d.hcnt = q.hcnt + 5'd1;
                        if (q.hcnt == half - 5'd1) begin
                            d.hcnt = 5'd0;
                            d.sck = ~q.sck;
                            d.ecnt = q.ecnt + 4'd1;
                            if (samp) begin
                                d.rbit = q.mi_s;
                            end else if (!(CFG.clock_phase &&
                                q.ecnt == 4'd0)) begin
                                d.sh = {q.sh[6:0], q.rbit};
                            end
                            if (q.ecnt == `SPC_LAST_EDGE) begin
                                byte_in = {q.sh[6:0], CFG.clock_phase ?
                                    q.mi_s : q.rbit};
                                d.sh = byte_in;
                                rx_evt = 1'b1;
                                d.st = S_IDLE;
                            end
                        end
                    end
                    default: d.st = S_IDLE;
                endcase
            end
            if (sl_on) begin
                if (done) begin
                    rx_evt = 1'b1;
                    byte_in = lk_buf;
                    d.slv_act = 1'b0;
                    if (q.stat.tx_buffer_empty_flag) begin
                        d.sh = lk_buf;
                    end
                end
                if (!CFG.clock_phase && q.ss_p && !q.ss_s) begin
                    d.slv_act = 1'b1;
                end
                if (CFG.select_fault_enable && q.slv_act &&
                    q.ss_s && !q.ss_p && !done) begin
                    d.stat.select_fault_flag = 1'b1;
                end
                if (!q.stat.tx_buffer_empty_flag && (q.ss_s || done)) begin
                    d.sh = q.txbuf;
                    d.stat.tx_buffer_empty_flag = 1'b1;
                end
            end
            if (rx_evt) begin
                if (d.stat.rx_full_flag) begin
                    d.stat.overrun_flag = 1'b1;
                end else begin
                    d.rxbuf = byte_in;
                    d.stat.rx_full_flag = 1'b1;
                end
            end
            if (!en_eff) begin
                d.stat.tx_buffer_empty_flag = 1'b1;
                d.st = S_IDLE;
                d.sh = `SPC_BYTE_RST;
                d.hcnt = 5'd0;
                d.ecnt = 4'd0;
                d.slv_act = 1'b0;
                d.sck = CFG.clock_polarity;
            end
            d.slv = sl_on;
            d.stat.enabled = CFG.unit_enable_bit & ~d.en_off;
            d.pins = en_eff;
            d.ss_own = en_eff & (~CFG.master_select |
                CFG.select_fault_enable);
            d.sck_oe = m_on;
            d.mosi_o = ~CFG.wired_or_select & d.sh[7];
            d.mosi_oe = m_on & (~CFG.wired_or_select | ~d.sh[7]);
            d.miso_oe = sl_on & ~q.ss_s;
            d.wake = PWR.wait_mode & (
                (d.stat.rx_full_flag & CFG.rx_irq_enable) |
                (d.stat.tx_buffer_empty_flag & CFG.tx_irq_enable) |
                (CFG.error_irq_enable & (d.stat.overrun_flag |
                d.stat.select_fault_flag)));
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            q <= '0;
            q.stat.tx_buffer_empty_flag <= `SPC_TXE_RST;
            q.st <= S_IDLE;
            q.ss_m <= 1'b1;
            q.ss_s <= 1'b1;
            q.ss_p <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign SCK_O = q.sck;
    assign SCK_OE = q.sck_oe;
    assign MOSI_O = q.mosi_o;
    assign MOSI_OE = q.mosi_oe;
    assign PINS_OWNED = q.pins;
    assign SS_OWNED = q.ss_own;
    assign WAKE = q.wake;
    assign STATUS = q.stat;
    assign RDATA = q.rxbuf;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    property p_idle_load;
        (q.st == S_IDLE && !q.stat.tx_buffer_empty_flag && m_on &&
            !PWR.stop_mode) |=> (q.stat.tx_buffer_empty_flag &&
            q.st == S_RUN);
    endproperty
    a_idle_load: assert property (p_idle_load)
        else $error("empty flag not set after load");

    property p_disable;
        (!CFG.unit_enable_bit && !PWR.stop_mode) |=>
            (q.stat.tx_buffer_empty_flag && q.st == S_IDLE &&
            q.sh == 8'h00);
    endproperty
    a_disable: assert property (p_disable)
        else $error("partial reset incomplete");

    property p_keep_flags;
        (!CFG.unit_enable_bit && !ACC.data_rd && !ACC.ctrl_wr) |=>
            $stable({q.stat.rx_full_flag, q.stat.overrun_flag,
            q.stat.select_fault_flag});
    endproperty
    a_keep_flags: assert property (p_keep_flags)
        else $error("flags changed while disabled");

    property p_fault_off;
        (m_on && CFG.select_fault_enable && !q.ss_s && !PWR.stop_mode)
            |=> (q.stat.select_fault_flag && !q.stat.enabled) ##1 !q.pins;
    endproperty
    a_fault_off: assert property (p_fault_off)
        else $error("select fault did not disable");

    property p_stop_hold;
        PWR.stop_mode |=> $stable(q);
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("state moved in stop");

    property p_wait_write;
        (PWR.wait_mode && !PWR.stop_mode && ACC.data_wr &&
            q.stat.tx_buffer_empty_flag) |=> q.stat.tx_buffer_empty_flag;
    endproperty
    a_wait_write: assert property (p_wait_write)
        else $error("write accepted in wait");

    property p_brk_write;
        (PWR.break_state && !PWR.break_clear_enable && ACC.data_wr &&
            q.stat.tx_buffer_empty_flag) |=> (q.stat.tx_buffer_empty_flag
            && $stable(q.txbuf));
    endproperty
    a_brk_write: assert property (p_brk_write)
        else $error("write took effect in break");

    property p_brk_flags;
        (PWR.break_state && !PWR.break_clear_enable && q.stat.rx_full_flag)
            |=> q.stat.rx_full_flag;
    endproperty
    a_brk_flags: assert property (p_brk_flags)
        else $error("flag cleared in protected break");

    property p_brk_clear;
        (PWR.break_state && PWR.break_clear_enable && !PWR.wait_mode &&
            !PWR.stop_mode && ACC.data_rd && !rx_evt) |=>
            !q.stat.rx_full_flag;
    endproperty
    a_brk_clear: assert property (p_brk_clear)
        else $error("flag not cleared in open break");

    property p_miso_dir;
        MISO_OE |-> (q.slv && !q.ss_p);
    endproperty
    a_miso_dir: assert property (p_miso_dir)
        else $error("data-out driven while unselected");

    property p_ss_owner;
        (!PWR.stop_mode) |=> (SS_OWNED == ($past(en_eff) &&
            (!$past(CFG.master_select) || $past(CFG.select_fault_enable))));
    endproperty
    a_ss_owner: assert property (p_ss_owner)
        else $error("select ownership wrong");

    property p_sck_dir;
        (!PWR.stop_mode) |=> (SCK_OE == $past(m_on) &&
            PINS_OWNED == $past(en_eff));
    endproperty
    a_sck_dir: assert property (p_sck_dir)
        else $error("pin ownership wrong");

    c_master_byte: cover property (q.st == S_RUN ##1 q.st == S_IDLE);
    c_slave_byte: cover property (done && sl_on);
    c_overrun: cover property ($rose(q.stat.overrun_flag));
    c_fault: cover property ($rose(q.stat.select_fault_flag));

endmodule : spc_core

//--- bench/spc_far.sv
`timescale 1ns/1ps
module spc_far (
    input wire logic SCK_O,
    input wire logic MOSI_O,
    input wire logic MOSI_OE,
    input wire logic MISO_O,
    input wire logic MISO_OE,
    output logic SCK_IN,
    output logic SS_N,
    output logic MOSI_I,
    output logic MISO_I
);
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    int edges;
    logic mosi_d;
    // The data line has a pull-up; the 1 ns lag keeps the value from before
    // the clock edge that may also move the data.
    assign #1 mosi_d = MOSI_OE ? MOSI_O : 1'b1;
    initial begin
        SCK_IN = 1'b0;
        SS_N = 1'b1;
        MOSI_I = 1'b0;
        MISO_I = 1'b0;
        tx_q = 8'h00;
        rx_q = 8'h00;
        edges = 0;
    end
    // Slave to a phase 1 master: next bit goes out on the leading edge.
    always @(posedge SCK_O) begin
        MISO_I <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
    end
    // Capture on the trailing edge; after the byte the line drifts.
    always @(negedge SCK_O) begin
        rx_q <= {rx_q[6:0], mosi_d};
        edges <= (edges == 7) ? 0 : edges + 1;
        if (edges == 7) begin
            MISO_I <= ~MISO_I;
        end
    end
    // Master with phase 0 timing; the link clock also runs when sel is low and SS_N stays high.
    task automatic xfer(input logic sel, input logic [7:0] out,
                        output logic [7:0] got, output logic oe);
        got = 8'h00;
        oe = 1'b0;
        SS_N = ~sel;
        #100;
        for (int i = 7; i >= 0; i--) begin
            MOSI_I = out[i];
            #24;
            got[i] = MISO_O;
            oe = oe | MISO_OE;
            SCK_IN = 1'b1;
            #24;
            SCK_IN = 1'b0;
        end
        MOSI_I = ~out[0];
        #100;
        SS_N = 1'b1;
    endtask : xfer
endmodule : spc_far

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import spc_pkg::*;
    logic clk;
    logic nrst;
    spc_cfg_t cfg;
    spc_acc_t acc;
    spc_pwr_t pwr;
    spc_stat_t status;
    logic [7:0] rdata;
    logic sck_in, ss_n, mosi_i, miso_i, sck_o, sck_oe, mosi_o, mosi_oe;
    logic miso_o, miso_oe, pins, ss_own, wake;
    logic [7:0] b, p, m, e, got;
    logic oe;
    logic [31:0] seed = 32'd42;
    int bad_count = 0;
    int checked = 0;

    spc_core spc_core_i (
        .CLK(clk), .NRST(nrst), .SCK_IN(sck_in), .SS_N(ss_n),
        .MOSI_I(mosi_i), .MISO_I(miso_i), .CFG(cfg), .ACC(acc),
        .PWR(pwr), .SCK_O(sck_o), .SCK_OE(sck_oe), .MOSI_O(mosi_o),
        .MOSI_OE(mosi_oe), .MISO_O(miso_o), .MISO_OE(miso_oe),
        .PINS_OWNED(pins), .SS_OWNED(ss_own), .WAKE(wake),
        .STATUS(status), .RDATA(rdata)
    );
    spc_far far_i (
        .SCK_O(sck_o), .MOSI_O(mosi_o), .MOSI_OE(mosi_oe), .MISO_O(miso_o),
        .MISO_OE(miso_oe), .SCK_IN(sck_in), .SS_N(ss_n),
        .MOSI_I(mosi_i), .MISO_I(miso_i)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    task automatic tally_and_finish;
        if (bad_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic put(input logic [7:0] v);
        @(posedge clk);
        acc.data_wr <= 1'b1;
        acc.wdata <= v;
        @(posedge clk);
        acc.data_wr <= 1'b0;
    endtask : put

    // Status read then data read: the two-step receive clear.
    task automatic clr_rx;
        @(posedge clk);
        acc.status_rd <= 1'b1;
        @(posedge clk);
        acc.status_rd <= 1'b0;
        acc.data_rd <= 1'b1;
        @(posedge clk);
        acc.data_rd <= 1'b0;
        @(posedge clk);
        #1;
    endtask : clr_rx

    task automatic wait_set(input logic [4:0] msk);
        int n;
        n = 0;
        while ((status & msk) !== msk) begin
            @(posedge clk);
            n++;
            if (n > 3000) begin
                chk("wait", 8'h00, 8'h01);
                tally_and_finish;
            end
        end
        #1;
    endtask : wait_set

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        nrst = 1'b0;
        cfg = '0;
        acc = '0;
        pwr = '0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        chk("status", 8'(status), 8'h08);
        chk("pins", {sck_oe, mosi_oe, miso_oe, pins, ss_own}, 8'h00);
        @(posedge clk);
        cfg.unit_enable_bit <= 1'b1;
        cfg.master_select <= 1'b1;
        cfg.clock_phase <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            b = (k == 0) ? 8'hff : seed[7:0];
            p = (k == 0) ? 8'h00 : seed[15:8];
            @(posedge clk);
            {cfg.baud_select_hi, cfg.baud_select_lo} <= k[1:0];
            cfg.wired_or_select <= (k == 3);
            far_i.tx_q = p;
            put(b);
            #1;
            chk("empty", 8'(status.tx_buffer_empty_flag), 8'h00);
            @(posedge clk);
            #1;
            chk("empty", 8'(status.tx_buffer_empty_flag), 8'h01);
            chk("owned", 8'(pins), 8'h01);
            chk("wired", 8'(mosi_o & cfg.wired_or_select), 8'h00);
            wait_set(5'h04);
            chk("rdata", rdata, p);
            chk("far rx", far_i.rx_q, b);
            clr_rx;
            chk("status", 8'(status), 8'h18);
        end
        seed = xs(seed);
        @(posedge clk);
        far_i.tx_q = 8'h5a;
        put(seed[7:0]);
        @(posedge clk);
        put(seed[15:8]);
        #1;
        chk("queued", 8'(status.tx_buffer_empty_flag), 8'h00);
        wait_set(5'h06);
        chk("kept", rdata, 8'h5a);
        @(posedge clk);
        cfg.unit_enable_bit <= 1'b0;
        cfg.wired_or_select <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("partial", 8'(status), 8'h0e);
        chk("pins", {sck_oe, mosi_oe, pins, ss_own}, 8'h00);
        clr_rx;
        chk("status", 8'(status), 8'h08);
        @(posedge clk);
        cfg.select_fault_enable <= 1'b1;
        cfg.unit_enable_bit <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("ss owned", 8'(ss_own), 8'h01);
        far_i.SS_N = 1'b0;
        wait_set(5'h01);
        repeat (3) @(posedge clk);
        #1;
        chk("fault", 8'(status), 8'h09);
        chk("pins", 8'(pins), 8'h00);
        far_i.SS_N = 1'b1;
        @(posedge clk);
        cfg.select_fault_enable <= 1'b0;
        cfg.unit_enable_bit <= 1'b0;
        @(posedge clk);
        cfg.unit_enable_bit <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("ss owned", 8'(ss_own), 8'h00);
        chk("fault kept", 8'(status), 8'h19);
        @(posedge clk);
        acc.status_rd <= 1'b1;
        @(posedge clk);
        acc.status_rd <= 1'b0;
        acc.ctrl_wr <= 1'b1;
        @(posedge clk);
        acc.ctrl_wr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("fault clear", 8'(status), 8'h18);
        @(posedge clk);
        cfg.master_select <= 1'b0;
        put(8'h3c);
        repeat (3) @(posedge clk);
        #1;
        chk("ss owned", 8'(ss_own), 8'h01);
        far_i.xfer(1'b0, 8'ha5, got, oe);
        chk("slave oe", 8'(oe), 8'h00);
        chk("ignored", 8'(status.rx_full_flag), 8'h00);
        e = 8'h3c;
        for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            m = seed[7:0];
            fork
                far_i.xfer(1'b1, m, got, oe);
                if (k == 0) begin
                    #300;
                    put(8'hc3);
                    #1;
                    chk("held", 8'(status.tx_buffer_empty_flag), 8'h00);
                end
            join
            chk("slave tx", got, e);
            chk("slave oe", 8'(oe), 8'h01);
            wait_set(5'h04);
            chk("slave rx", rdata, m);
            clr_rx;
            e = (k == 0) ? 8'hc3 : m;
        end
        far_i.xfer(1'b1, 8'h77, got, oe);
        wait_set(5'h04);
        @(posedge clk);
        pwr.break_state <= 1'b1;
        clr_rx;
        chk("locked", 8'(status.rx_full_flag), 8'h01);
        @(posedge clk);
        pwr.break_clear_enable <= 1'b1;
        clr_rx;
        @(posedge clk);
        pwr.break_state <= 1'b0;
        pwr.break_clear_enable <= 1'b0;
        @(posedge clk);
        #1;
        chk("cleared", 8'(status.rx_full_flag), 8'h00);
        @(posedge clk);
        cfg.master_select <= 1'b1;
        pwr.break_state <= 1'b1;
        put(8'h81);
        repeat (300) @(posedge clk);
        #1;
        chk("no start", 8'(status) & 8'h0c, 8'h08);
        @(posedge clk);
        pwr.break_state <= 1'b0;
        pwr.wait_mode <= 1'b1;
        cfg.tx_irq_enable <= 1'b1;
        put(8'h42);
        repeat (2) @(posedge clk);
        #1;
        chk("wait write", 8'(status.tx_buffer_empty_flag), 8'h01);
        chk("wake", 8'(wake), 8'h01);
        @(posedge clk);
        pwr.wait_mode <= 1'b0;
        cfg.tx_irq_enable <= 1'b0;
        far_i.tx_q = 8'h99;
        put(8'h24);
        repeat (20) @(posedge clk);
        pwr.stop_mode <= 1'b1;
        repeat (400) @(posedge clk);
        #1;
        chk("stopped", 8'(status) & 8'h0c, 8'h08);
        @(posedge clk);
        pwr.stop_mode <= 1'b0;
        wait_set(5'h04);
        chk("resumed", rdata, 8'h99);
        put(8'h55);
        repeat (20) @(posedge clk);
        pwr.stop_mode <= 1'b1;
        repeat (5) @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("reset", 8'(status), 8'h08);
        chk("reset data", rdata, 8'h00);
        @(posedge clk);
        nrst <= 1'b1;
        pwr.stop_mode <= 1'b0;
        repeat (300) @(posedge clk);
        #1;
        chk("aborted", 8'(status) & 8'h0c, 8'h08);
        tally_and_finish;
    end
endmodule : tb_top
